// file: core/adc_host_if.sv
// Parallel host interface, conversion sequencing and result registers
`timescale 1ns/10ps
module adc_host_if (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic        I_CONV_CLK,
    input  wire logic        I_CS_N,
    input  wire logic        I_RD_N,
    input  wire logic        I_WR_N,
    input  wire logic [2:0]  I_ADDR,
    input  wire logic        I_ADD,
    input  wire logic        I_RST_N,
    input  wire logic        I_SAMPLE_TRIGGER_A_N,
    input  wire logic        I_SAMPLE_TRIGGER_B_N,
    input  wire logic        I_SAMPLE_TRIGGER_C_N,
    input  wire logic [15:0] I_DATA,
    input  wire logic [15:0] I_CHANNEL_A_FIRST,
    input  wire logic [15:0] I_CHANNEL_A_SECOND,
    input  wire logic [15:0] I_CHANNEL_B_FIRST,
    input  wire logic [15:0] I_CHANNEL_B_SECOND,
    input  wire logic [15:0] I_CHANNEL_C_FIRST,
    input  wire logic [15:0] I_CHANNEL_C_SECOND,
    output logic [15:0]      O_DATA,
    output logic             O_DATA_OE,
    output logic             O_CONVERSION_DONE_N,
    output logic             O_FIRST_WORD_FLAG
);
    typedef struct packed {
        logic                                          conv_q;
        logic                                          wr_q;
        logic                                          rd_q;
        logic [2:0]                                    trig_q;
        logic [1:0]                                    wr_low;
        logic                                          fmt_bin;
        logic                                          cfg_add;
        logic [2:0]                                    cfg_sel;
        logic [2:0]                                    soft_go;
        logic                                          soft_rst;
        adc_if_pkg::pair_state_t [2:0]                 ps;
        logic [2:0][4:0]                               cnt;
        logic [5:0][15:0]                              codes;
        logic [2:0]                                    done_pend;
        logic                                          push_busy;
        logic                                          push_ph;
        logic [1:0]                                    push_pair;
        logic [1:0]                                    push_dest;
        logic [1:0]                                    qslot;
        logic [5:0][15:0]                              regs;
        logic [2:0]                                    rptr;
        logic                                          addr_ph;
        logic [1:0]                                    eoc_pend;
        logic                                          eoc_low;
        logic [15:0]                                   out_data;
        logic                                          out_oe;
        logic                                          done_n;
        logic                                          first;
    } core_state_t;

    core_state_t q;
    core_state_t d;

    logic        rst_meta;
    logic        rst_sync_n;

    logic        conv_rise;
    logic        conv_fall;
    logic        wr_fall;
    logic        wr_rise;
    logic        rd_rise;
    logic        reading;
    logic        eff_rst;
    logic        eff_add;
    logic [2:0]  eff_sel;
    logic        seq_mode;
    logic        queue_mode;
    logic [2:0]  trig_n;
    logic [2:0]  eff_trig_n;
    logic [2:0]  rd_idx;
    logic [15:0] code_word;
    logic [95:0] chan_in;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [18:0] fifo_in_data;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [18:0] fifo_out_data;
    logic [1:0]  pick;
    logic        pick_any;
    logic [1:0]  eoc_add;

    // Reset release through two flops
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign trig_n  = {I_SAMPLE_TRIGGER_C_N, I_SAMPLE_TRIGGER_B_N, I_SAMPLE_TRIGGER_A_N};
    assign chan_in = {I_CHANNEL_C_SECOND, I_CHANNEL_C_FIRST, I_CHANNEL_B_SECOND,
                      I_CHANNEL_B_FIRST, I_CHANNEL_A_SECOND, I_CHANNEL_A_FIRST};

    // Results travel through the FIFO tagged with their register index
    sample_fifo #(
        .WIDTH (adc_if_pkg::FIFO_W),
        .DEPTH (adc_if_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (rst_sync_n),
        .i_flush     (eff_rst),
        .i_in_valid  (fifo_in_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data)
    );

    always_comb
    begin
        d = q;

        conv_rise  = I_CONV_CLK && !q.conv_q;
        conv_fall  = !I_CONV_CLK && q.conv_q;
        wr_fall    = !I_CS_N && q.wr_q && !I_WR_N;
        wr_rise    = !I_CS_N && !q.wr_q && I_WR_N;
        rd_rise    = !I_CS_N && !q.rd_q && I_RD_N;
        reading    = !I_CS_N && !I_RD_N;
        eff_rst    = !I_RST_N || q.soft_rst;
        eff_add    = q.cfg_add || I_ADD;
        eff_sel    = q.cfg_sel | I_ADDR;
        seq_mode   = (eff_sel == adc_if_pkg::SEL_SEQ);
        queue_mode = (eff_sel == adc_if_pkg::SEL_QUEUE);
        eff_trig_n = trig_n & ~q.soft_go;

        d.conv_q = I_CONV_CLK;
        d.wr_q   = I_WR_N;
        d.rd_q   = I_RD_N;
        d.trig_q = eff_trig_n;
        d.soft_go  = 3'h0;
        d.soft_rst = 1'b0;

        // Command writes on the low byte of the data pins
        if (!I_CS_N && !I_WR_N)
        begin
            if (q.wr_low != adc_if_pkg::WR_LOW_CYC)
            begin
                d.wr_low = q.wr_low + 1'b1;
            end
        end
        else
        begin
            d.wr_low = 2'h0;
        end
        if (wr_fall && !I_DATA[adc_if_pkg::CMD_KIND_BIT])
        begin
            if (I_DATA[2:0] == adc_if_pkg::CMD_RESET)
            begin
                d.soft_rst = 1'b1;
            end
            else
            begin
                d.soft_go = ~I_DATA[2:0];
            end
        end
        if (wr_rise && I_DATA[adc_if_pkg::CMD_KIND_BIT]
            && q.wr_low == adc_if_pkg::WR_LOW_CYC)
        begin
            d.fmt_bin = I_DATA[adc_if_pkg::CMD_FMT_BIT];
            d.cfg_add = I_DATA[adc_if_pkg::CMD_ADD_BIT];
            d.cfg_sel = I_DATA[adc_if_pkg::CMD_SEL_LSB +: 3];
            d.rptr    = adc_if_pkg::SEL_A_FIRST;
            d.addr_ph = 1'b0;
        end

        // Per-pair sampling and conversion timing
        eoc_add = 2'h0;
        for (int p = 0; p < adc_if_pkg::NUM_PAIRS; p++)
        begin
            case (q.ps[p])
                adc_if_pkg::PAIR_IDLE:
                begin
                    if (!eff_trig_n[p] && q.trig_q[p] && !q.done_pend[p])
                    begin
                        d.codes[2*p]   = chan_in[32*p +: 16];
                        d.codes[2*p+1] = chan_in[32*p+16 +: 16];
                        d.ps[p]        = adc_if_pkg::PAIR_ARMED;
                    end
                end
                adc_if_pkg::PAIR_ARMED:
                begin
                    if (conv_rise)
                    begin
                        d.cnt[p] = 5'h01;
                        d.ps[p]  = adc_if_pkg::PAIR_CONV;
                    end
                end
                adc_if_pkg::PAIR_CONV:
                begin
                    if (conv_rise)
                    begin
                        if (q.cnt[p] != adc_if_pkg::CONV_CLKS)
                        begin
                            d.cnt[p] = q.cnt[p] + 1'b1;
                        end
                        else if (!q.done_pend[p])
                        begin
                            d.done_pend[p] = 1'b1;
                            d.ps[p]        = adc_if_pkg::PAIR_IDLE;
                            eoc_add        = eoc_add + 1'b1;
                        end
                    end
                end
                default:
                begin
                    d.ps[p] = adc_if_pkg::PAIR_IDLE;
                end
            endcase
        end

        // Done strobe: low from a converter-clock rise to the next fall
        if (q.eoc_low && conv_fall)
        begin
            d.eoc_low = 1'b0;
        end
        else if (!q.eoc_low && conv_rise && q.eoc_pend != 2'h0)
        begin
            d.eoc_low = 1'b1;
        end
        d.eoc_pend = q.eoc_pend + eoc_add
                     - 2'((!q.eoc_low && conv_rise && q.eoc_pend != 2'h0) ? 1 : 0);

        // Push finished pairs into the FIFO, two words each
        pick     = 2'h0;
        pick_any = 1'b0;
        for (int p = adc_if_pkg::NUM_PAIRS - 1; p >= 0; p--)
        begin
            if (q.done_pend[p])
            begin
                pick     = 2'(p);
                pick_any = 1'b1;
            end
        end
        if (!q.push_busy && pick_any)
        begin
            d.push_busy = 1'b1;
            d.push_ph   = 1'b0;
            d.push_pair = pick;
            d.push_dest = queue_mode ? q.qslot : pick;
            if (queue_mode)
            begin
                d.qslot = (q.qslot == adc_if_pkg::SLOT_LAST) ? 2'h0 : q.qslot + 1'b1;
            end
        end
        code_word = q.codes[{q.push_pair, q.push_ph}];
        // Front-end codes are two's complement; straight binary flips the sign bit
        if (q.fmt_bin)
        begin
            code_word[adc_if_pkg::SIGN_BIT] = ~code_word[adc_if_pkg::SIGN_BIT];
        end
        fifo_in_valid = q.push_busy;
        fifo_in_data  = {q.push_dest, q.push_ph, code_word};
        if (q.push_busy && fifo_in_ready)
        begin
            if (q.push_ph)
            begin
                d.push_busy              = 1'b0;
                d.done_pend[q.push_pair] = 1'b0;
            end
            d.push_ph = ~q.push_ph;
        end

        // Drain into the data registers, never under a read access
        fifo_out_ready = !reading;
        if (fifo_out_valid && !reading)
        begin
            d.regs[fifo_out_data[18:16]] = fifo_out_data[15:0];
        end

        // Read pointer advance and address-word phase
        if (rd_rise)
        begin
            if (eff_add && !q.addr_ph)
            begin
                d.addr_ph = 1'b1;
            end
            else
            begin
                d.addr_ph = 1'b0;
                if (seq_mode || queue_mode)
                begin
                    d.rptr = (q.rptr == adc_if_pkg::SEL_LAST_CH)
                             ? adc_if_pkg::SEL_A_FIRST : q.rptr + 1'b1;
                end
            end
        end

        rd_idx = (seq_mode || queue_mode) ? q.rptr : eff_sel;
        if (eff_add && !q.addr_ph)
        begin
            d.out_data = {13'h0000, rd_idx};
        end
        else
        begin
            d.out_data = q.regs[rd_idx];
        end
        d.out_oe  = !I_CS_N;
        d.done_n  = !q.eoc_low;
        d.first   = reading && !(eff_add && !q.addr_ph)
                    && rd_idx == adc_if_pkg::SEL_A_SECOND;

        // Pin or soft reset clears results and pointers
        if (eff_rst)
        begin
            d.rptr      = adc_if_pkg::SEL_A_FIRST;
            d.addr_ph   = 1'b0;
            d.regs      = '0;
            d.ps        = '{default: adc_if_pkg::PAIR_IDLE};
            d.cnt       = '0;
            d.done_pend = 3'h0;
            d.push_busy = 1'b0;
            d.push_ph   = 1'b0;
            d.qslot     = 2'h0;
            d.eoc_pend  = 2'h0;
            d.eoc_low   = 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            q          <= '0;
            q.conv_q   <= 1'b0;
            q.wr_q     <= 1'b1;
            q.rd_q     <= 1'b1;
            q.trig_q   <= 3'h7;
            q.done_n   <= 1'b1;
            q.out_data <= adc_if_pkg::DATA_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign O_DATA              = q.out_data;
    assign O_DATA_OE           = q.out_oe;
    assign O_CONVERSION_DONE_N = q.done_n;
    assign O_FIRST_WORD_FLAG   = q.first;

endmodule

// file: core/adc_if_pkg.sv
// Constants and types shared by the converter host interface and its FIFO
// Summary of operation
// - Data pins float unless chip select low
// - Address codes: six channels, sequential, queue
// - Soft convert/reset ANDed with trigger/reset pins
// - Soft address/mode bits ORed with pins
// - Convert on write fall, configure on rise
// - Low byte carries commands; D7 picks kind
// - D4 chooses straight binary or two's complement
// - Zero bits 2..0 start matching pairs
// - Word 0x0007 resets; output restarts at A0
// - Reset pin returns read pointer to start
// - All triggers low sample all six together
// - Done after 20 clocks; strobe half cycle
// - One done strobe per converted pair
// - Queue mode fills register pairs by arrival
// - Otherwise each trigger owns its register pair
// - Host reads before next strobe overwrites
// - Results kept until overwritten or reset
// - Channel select then read base location
// - Word 0x0086 selects sequential read mode
// - First word flag marks channel A second
package adc_if_pkg;

    localparam int unsigned DATA_W       = 16;
    localparam int unsigned NUM_CH       = 6;
    localparam int unsigned NUM_PAIRS    = 3;
    localparam int unsigned IDX_W        = 3;
    localparam int unsigned FIFO_W       = DATA_W + IDX_W;
    localparam int unsigned FIFO_DEPTH   = 16;

    // Converter clocks from start of conversion to completion
    localparam logic [4:0]  CONV_CLKS    = 5'h14;

    // Least write-strobe low time before a configuration word is taken
    localparam int unsigned SYS_CLK_MHZ  = 100;
    localparam int unsigned WR_LOW_NS    = 20;
    localparam int unsigned WR_LOW_CYC_I = (WR_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [1:0]  WR_LOW_CYC   = 2'(WR_LOW_CYC_I);

    // Address and mode codes
    localparam logic [2:0]  SEL_A_FIRST  = 3'h0;
    localparam logic [2:0]  SEL_A_SECOND = 3'h1;
    localparam logic [2:0]  SEL_LAST_CH  = 3'h5;
    localparam logic [2:0]  SEL_SEQ      = 3'h6;
    localparam logic [2:0]  SEL_QUEUE    = 3'h7;

    // Command word fields
    localparam int unsigned CMD_KIND_BIT = 7;
    localparam int unsigned CMD_FMT_BIT  = 4;
    localparam int unsigned CMD_ADD_BIT  = 3;
    localparam int unsigned CMD_SEL_LSB  = 0;
    localparam logic [2:0]  CMD_RESET    = 3'h7;
    localparam int unsigned SIGN_BIT     = DATA_W - 1;

    localparam logic [15:0] DATA_RESET   = 16'h0000;
    localparam logic [1:0]  SLOT_LAST    = 2'h2;

    typedef enum logic [1:0] {
        PAIR_IDLE,
        PAIR_ARMED,
        PAIR_CONV
    } pair_state_t;

endpackage

// file: core/sample_fifo.sv
// Parameterised first-word-fall-through FIFO with registered output word
`timescale 1ns/10ps
module sample_fifo #(
    parameter int unsigned WIDTH = 19,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic        push;
    logic        load;
    logic        pop;

    always_comb
    begin
        d    = q;
        push = i_in_valid && (q.cnt != (AW+1)'(DEPTH));
        pop  = q.ov && i_out_ready;
        load = (q.cnt != '0) && (!q.ov || pop);
        if (push)
        begin
            d.mem[q.wp] = i_in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (load)
        begin
            d.od = q.mem[q.rp];
            d.rp = q.rp + 1'b1;
            d.ov = 1'b1;
        end
        else if (pop)
        begin
            d.ov = 1'b0;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
        if (i_flush)
        begin
            d.wp  = '0;
            d.rp  = '0;
            d.cnt = '0;
            d.ov  = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = q.ov;
    assign o_out_data  = q.od;

endmodule

// file: verification/adc_host_if_props.sv
// Port-level concurrent checks for the converter host interface
`timescale 1ns/10ps
module adc_host_if_props (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RESET_N,
    input wire logic        I_CONV_CLK,
    input wire logic        I_CS_N,
    input wire logic        I_RD_N,
    input wire logic        I_RST_N,
    input wire logic [15:0] O_DATA,
    input wire logic        O_DATA_OE,
    input wire logic        O_CONVERSION_DONE_N,
    input wire logic        O_FIRST_WORD_FLAG
);
    logic       conv_q;
    logic [4:0] rise_cnt_q;
    wire        rd_on = !I_CS_N && !I_RD_N;

    // Converter clock rises since the last device reset, saturating
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            conv_q     <= 1'b0;
            rise_cnt_q <= 5'h00;
        end
        else
        begin
            conv_q <= I_CONV_CLK;
            if (!I_RST_N)
                rise_cnt_q <= 5'h00;
            else if (I_CONV_CLK && !conv_q && rise_cnt_q != 5'h1f)
                rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    sequence s_read_held;
        rd_on [*3];
    endsequence
    sequence s_done_window;
        !O_CONVERSION_DONE_N [*3] ##[1:3] O_CONVERSION_DONE_N;
    endsequence

    a_oe_follows_cs: assert property (##1 (O_DATA_OE == !$past(I_CS_N)))
        else $error("data pin enable does not follow chip select");
    a_read_data_steady: assert property (s_read_held |-> $stable(O_DATA))
        else $error("read data moved during a held read");
    a_flag_needs_read: assert property (O_FIRST_WORD_FLAG |-> $past(rd_on))
        else $error("first word flag outside a read");
    a_done_on_high: assert property ($fell(O_CONVERSION_DONE_N) |-> I_CONV_CLK)
        else $error("done strobe began in clock low phase");
    a_done_half_clk: assert property ($fell(O_CONVERSION_DONE_N) |-> s_done_window)
        else $error("done strobe width wrong");
    a_done_ends_low: assert property ($rose(O_CONVERSION_DONE_N) |-> !I_CONV_CLK)
        else $error("done strobe ended in clock high phase");
    a_done_after_reset: assert property ($fell(O_CONVERSION_DONE_N) |-> rise_cnt_q >= 5'h14)
        else $error("done strobe too soon after device reset");
    a_done_spacing: assert property ($rose(O_CONVERSION_DONE_N) |-> O_CONVERSION_DONE_N [*3])
        else $error("done strobes too close");
endmodule

bind adc_host_if adc_host_if_props props_u (
    .I_SYS_CLK (I_SYS_CLK), .I_RESET_N (I_RESET_N), .I_CONV_CLK (I_CONV_CLK),
    .I_CS_N (I_CS_N), .I_RD_N (I_RD_N), .I_RST_N (I_RST_N), .O_DATA (O_DATA),
    .O_DATA_OE (O_DATA_OE), .O_CONVERSION_DONE_N (O_CONVERSION_DONE_N),
    .O_FIRST_WORD_FLAG (O_FIRST_WORD_FLAG)
);

// file: verification/host_bus_model.sv
// Processor host model: parallel bus cycles and control pins
`timescale 1ns/10ps
module host_bus_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_flag,
    output logic             o_cs_n,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic [2:0]       o_addr,
    output logic             o_add,
    output logic             o_rst_n,
    output logic [2:0]       o_trig_n,
    output logic [15:0]      o_data,
    output logic             o_data_oe
);
    initial
    begin
        {o_cs_n, o_rd_n, o_wr_n, o_rst_n} = 4'hf;
        {o_addr, o_add, o_trig_n} = 7'h07;
        o_data    = 16'h0000;
        o_data_oe = 1'b0;
    end

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    // Select low for four cycles, strobe low for three; released data shows its inverse
    task automatic write_word(input logic [15:0] word);
        step();
        {o_cs_n, o_wr_n, o_data_oe} = 3'h1;
        o_data = word;
        repeat (2) @(posedge i_clk);
        step();
        o_wr_n = 1'b1;
        step();
        {o_cs_n, o_data_oe} = 2'h2;
        o_data = ~word;
    endtask

    task automatic read_word(input logic [2:0] sel, output logic [15:0] word,
                             output logic flag);
        step();
        {o_cs_n, o_rd_n} = 2'h0;
        o_addr = sel;
        repeat (2) @(posedge i_clk);
        step();
        word = i_rdata;
        flag = i_flag;
        o_rd_n = 1'b1;
        step();
        o_cs_n = 1'b1;
        o_addr = 3'h0;
    endtask

    task automatic set_add(input logic level);
        step();
        o_add = level;
    endtask

    task automatic pulse_pins(input logic [2:0] trig_low, input logic rst_low);
        step();
        o_trig_n = ~trig_low;
        o_rst_n  = ~rst_low;
        repeat (12) @(posedge i_clk);
        #1;
        {o_trig_n, o_rst_n} = 4'hf;
    endtask
endmodule

// file: verification/six_channel_adc_host_interface_test.sv
// Self-checking bench for the six-channel converter host interface
`timescale 1ns/10ps
module six_channel_adc_host_interface_test;
    logic        sys_clk;
    logic        reset_n;
    logic        conv_clk;
    logic [15:0] ch [6];
    logic [15:0] rdata, host_data, got;
    logic        got_flag, cs_n, rd_n, wr_n, add, rst_n, host_oe, oe, done_n, flag;
    logic [2:0]  addr, trig_n;
    wire  [15:0] bus_w = (oe && !host_oe) ? rdata : host_data;
    int          mismatches, num_checks, strobes;

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    initial
    begin
        conv_clk = 1'b0;
        #3;
        forever #40 conv_clk = ~conv_clk;
    end

    adc_host_if dut_u (
        .I_SYS_CLK (sys_clk), .I_RESET_N (reset_n), .I_CONV_CLK (conv_clk),
        .I_CS_N (cs_n), .I_RD_N (rd_n), .I_WR_N (wr_n), .I_ADDR (addr), .I_ADD (add),
        .I_RST_N (rst_n), .I_SAMPLE_TRIGGER_A_N (trig_n[0]),
        .I_SAMPLE_TRIGGER_B_N (trig_n[1]), .I_SAMPLE_TRIGGER_C_N (trig_n[2]),
        .I_DATA (bus_w), .I_CHANNEL_A_FIRST (ch[0]), .I_CHANNEL_A_SECOND (ch[1]),
        .I_CHANNEL_B_FIRST (ch[2]), .I_CHANNEL_B_SECOND (ch[3]),
        .I_CHANNEL_C_FIRST (ch[4]), .I_CHANNEL_C_SECOND (ch[5]), .O_DATA (rdata),
        .O_DATA_OE (oe), .O_CONVERSION_DONE_N (done_n), .O_FIRST_WORD_FLAG (flag)
    );
    host_bus_model host_u (
        .i_clk (sys_clk), .i_rdata (bus_w), .i_flag (flag), .o_cs_n (cs_n),
        .o_rd_n (rd_n), .o_wr_n (wr_n), .o_addr (addr), .o_add (add), .o_rst_n (rst_n),
        .o_trig_n (trig_n), .o_data (host_data), .o_data_oe (host_oe)
    );

    always @(negedge done_n)
        strobes++;

    task automatic check16(input logic [15:0] got_v, input logic [15:0] exp_v);
        num_checks++;
        if (got_v !== exp_v)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic count_strobes(input logic [15:0] exp_n);
        strobes = 0;
        repeat (700) @(posedge sys_clk);
        check16(16'(strobes), exp_n);
    endtask

    task automatic read_all(input logic [15:0] flip);
        for (int i = 0; i < 6; i++)
        begin
            host_u.read_word(3'h0, got, got_flag);
            check16(got, ch[i] ^ flip);
            check16({15'h0000, got_flag}, {15'h0000, i == 1});
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (8000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end

    initial
    begin
        reset_n    = 1'b0;
        mismatches = 0;
        num_checks = 0;
        strobes    = 0;
        ch = '{16'h8123, 16'h0456, 16'hf789, 16'h7abc, 16'h1def, 16'hc001};
        repeat (10) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        host_u.write_word(16'h0086);
        host_u.write_word(16'h0008);
        count_strobes(16'h0003);
        read_all(16'h0000);
        read_all(16'h0000);
        // Leave the pointer off the first register, then pulse the reset pin
        host_u.read_word(3'h0, got, got_flag);
        host_u.pulse_pins(3'h0, 1'b1);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, 16'h0000);
        check16({15'h0000, got_flag}, 16'h0000);
        for (int i = 0; i < 6; i++)
            ch[i] = ch[i] ^ 16'h0f0f;
        host_u.write_word(16'h0096);
        host_u.pulse_pins(3'h7, 1'b0);
        count_strobes(16'h0003);
        read_all(16'h8000);
        host_u.write_word(16'h0083);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, ch[3] ^ 16'h8000);
        host_u.write_word(16'h0081);
        host_u.read_word(3'h4, got, got_flag);
        check16(got, ch[5] ^ 16'h8000);
        // Soft reset, then queue mode with trigger C alone
        host_u.write_word(16'h0007);
        host_u.write_word(16'h0087);
        host_u.pulse_pins(3'h4, 1'b0);
        count_strobes(16'h0001);
        host_u.write_word(16'h0080);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, ch[4]);
        host_u.write_word(16'h0084);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, 16'h0000);
        // Trigger B alone outside queue mode fills its own pair
        host_u.write_word(16'h0082);
        host_u.pulse_pins(3'h2, 1'b0);
        count_strobes(16'h0001);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, ch[2]);
        host_u.write_word(16'h0080);
        host_u.read_word(3'h0, got, got_flag);
        check16(got, ch[4]);
        // Address-output pin: index word first, then that channel's data
        host_u.set_add(1'b1);
        host_u.read_word(3'h3, got, got_flag);
        check16(got, 16'h0003);
        host_u.read_word(3'h3, got, got_flag);
        check16(got, ch[3]);
        host_u.set_add(1'b0);
        stop_test();
    end
endmodule
